// *** design/power_mode_manager.sv ***
// Operation
// - POWER_SAVE_REQUEST write, no wait bit: switch now
// - with wait bit, POWER_SAVE_REQUEST waits for WAIT
// - deferred POWER_SAVE_REQUEST reads set at once
// - POWER_SAVE_REQUEST cleared by software or wake
// - IDLE entered at WAIT; wake clears it
// - Halt stops system clock, then oscillators
// - Halt exit: oscillator stable, then clear
// - deferred disables act after mode entry
// - MAIN_OSC_DISABLE gates oscillator only in Save/Idle
// - wake clears MAIN_OSC_DISABLE and PLL_DISABLE
// - PLL_DISABLE or power-down gates PLL
// - HW_CTRL_MAIN_OSC gates oscillator while link sleeps
// - HW_CTRL_PLL gates PLL while link sleeps
// - low oscillator unstable blocks low modes
// - main oscillator unstable blocks Active
// - PLL unstable blocks Active
// - status upper bits zero, low live
// - control register clears at reset
// - wake event latched until acknowledge
// - wake restores clocks, not execution
// - immediate Save keeps CPU on slow clock
// - wake sequence main, then PLL, Active
// - switch held until clock stable
// - disable bits override hardware control
//
// Our own choices: the APB interface to the registers and the register addresses.
module power_mode_manager
  import pmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_exec,
  input wire logic wake_event,
  input wire logic int_ack,
  input wire logic link_sleep,
  input wire logic pll_power_down,
  input wire clk_status_s clk_status,
  output clk_ctrl_s clk_ctrl,
  output logic wake_pending,
  output pmode_e mode
);

  // ============================================================
  // state
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  pmode_e mode_reg;
  pmode_e mode_next;
  logic [1:0] target_reg;
  logic [1:0] target_next;
  logic wake_reg;
  logic wait_seen_reg;
  logic [7:0] stop_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  clk_ctrl_s clk_ctrl_reg;
  clk_ctrl_s clk_ctrl_next;

  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_SAVE = 2'h1;
  localparam logic [1:0] TGT_IDLE = 2'h2;
  localparam logic [1:0] TGT_HALT = 2'h3;

  logic setup;
  logic access_edge;
  logic wr_ctrl;
  logic rd_hit;
  logic in_low;
  logic wake_now;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == CTRL_ADDR) || (a == STAT_ADDR);
  endfunction

  function automatic logic [31:0] status_word(input clk_status_s s);
    status_word = {29'h0000_0000, s.pll_stable, s.main_osc_stable, s.low_osc_stable};
  endfunction

  assign setup = psel && !penable;
  // writes land on the edge at which the master samples pready
  assign access_edge = psel && penable && pready_reg;
  assign wr_ctrl = access_edge && pwrite && paddr == CTRL_ADDR && pstrb[0];
  assign rd_hit = addr_known(paddr);
  assign in_low = mode_reg == ST_SAVE || mode_reg == ST_IDLE;
  assign wake_now = wake_reg || wake_event;

  // ============================================================
  // wake latch
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wake_reg <= 1'b0;
    // set wins over acknowledge
    else if (wake_event)
      wake_reg <= 1'b1;
    else if (int_ack)
      wake_reg <= 1'b0;
  end

  // ============================================================
  // mode and control register next values
  always_comb
  begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    target_next = target_reg;
    if (wr_ctrl)
    begin
      ctrl_next = pwdata[7:0];
      // POWER_SAVE_REQUEST reads live state unless a deferred request
      ctrl_next[PSM_BIT] = ctrl_reg[PSM_BIT];
      if (pwdata[PSM_BIT] && !ctrl_reg[PSM_BIT])
      begin
        if (pwdata[WBE_BIT])
        begin
          ctrl_next[PSM_BIT] = 1'b1;
          target_next = TGT_SAVE;
        end
        else if (mode_reg == ST_ACTIVE)
          target_next = TGT_SAVE;
      end
      else if (!pwdata[PSM_BIT] && ctrl_reg[PSM_BIT])
      begin
        if (mode_reg == ST_SAVE)
        begin
          ctrl_next[PSM_BIT] = 1'b1;
          mode_next = ST_WAKE_MAIN;
        end
        else
        begin
          ctrl_next[PSM_BIT] = 1'b0;
          target_next = TGT_NONE;
        end
      end
      if (pwdata[WBE_BIT] && (mode_reg == ST_ACTIVE || mode_reg == ST_SAVE))
      begin
        if (pwdata[HALT_BIT])
          target_next = TGT_HALT;
        else if (pwdata[IDLE_BIT])
          target_next = TGT_IDLE;
      end
    end
    case (mode_reg)
      ST_ACTIVE, ST_SAVE:
      begin
        // immediate Save taken without WAIT; CPU stays on slow clock
        if (mode_reg == ST_ACTIVE && target_next == TGT_SAVE && !ctrl_next[WBE_BIT]
            && clk_status.low_osc_stable)
        begin
          mode_next = ST_SAVE;
          ctrl_next[PSM_BIT] = 1'b1;
          target_next = TGT_NONE;
        end
        else if ((wait_exec || wait_seen_reg) && target_reg != TGT_NONE && ctrl_reg[WBE_BIT]
                 && clk_status.low_osc_stable)
        begin
          target_next = TGT_NONE;
          if (target_reg == TGT_HALT)
            mode_next = ST_HALT_STOP;
          else if (target_reg == TGT_IDLE)
            mode_next = ST_IDLE;
          else
            mode_next = ST_SAVE;
        end
        if (wake_now && in_low)
          mode_next = ST_WAKE_MAIN;
      end
      ST_IDLE:
        if (wake_now)
          mode_next = ST_WAKE_MAIN;
      // short gap between system clock stop and oscillator stop
      ST_HALT_STOP:
        if (stop_cnt_reg >= 8'(HALT_STOP_CYC))
          mode_next = ST_HALT;
      ST_HALT:
        if (wake_now)
          mode_next = ST_WAKE_MAIN;
      ST_WAKE_MAIN:
      begin
        if (wake_now)
          ctrl_next[DMC_BIT] = 1'b0;
        // a software exit waits here until the disable bit is cleared
        if (!ctrl_next[DMC_BIT] && clk_status.main_osc_stable)
          mode_next = ST_WAKE_PLL;
      end
      ST_WAKE_PLL:
      begin
        if (wake_now)
          ctrl_next[DHC_BIT] = 1'b0;
        if (clk_status.pll_stable && clk_status.main_osc_stable)
        begin
          mode_next = ST_ACTIVE;
          ctrl_next[PSM_BIT] = 1'b0;
          ctrl_next[IDLE_BIT] = 1'b0;
          ctrl_next[HALT_BIT] = 1'b0;
          ctrl_next[HW_CTRL_MAIN_OSC_BIT] = 1'b0;
          ctrl_next[HW_CTRL_PLL_BIT] = 1'b0;
          target_next = TGT_NONE;
        end
      end
      default:
        mode_next = ST_ACTIVE;
    endcase
  end

  // ============================================================
  // register updates, one block per concern
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_reg <= CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode_reg <= ST_ACTIVE;
    else
      mode_reg <= mode_next;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      target_reg <= TGT_NONE;
    else
      target_reg <= target_next;
  end

  // ============================================================
  // a WAIT taken while the slow clock is unstable stays armed
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wait_seen_reg <= 1'b0;
    else if (target_next == TGT_NONE || mode_next != mode_reg)
      wait_seen_reg <= 1'b0;
    else if (wait_exec && target_reg != TGT_NONE && ctrl_reg[WBE_BIT])
      wait_seen_reg <= 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      stop_cnt_reg <= 8'h00;
    else if (mode_reg == ST_HALT_STOP)
      stop_cnt_reg <= stop_cnt_reg + 8'h01;
    else
      stop_cnt_reg <= 8'h00;
  end

  // ============================================================
  // clock gating
  always_comb
  begin
    clk_ctrl_next.sys_clk_run = 1'b1;
    clk_ctrl_next.sys_clk_slow = 1'b0;
    clk_ctrl_next.main_osc_en = 1'b1;
    clk_ctrl_next.pll_en = !pll_power_down;
    case (mode_next)
      ST_SAVE, ST_IDLE:
      begin
        clk_ctrl_next.sys_clk_run = mode_next == ST_SAVE;
        clk_ctrl_next.sys_clk_slow = 1'b1;
        // disable bits win over link control; applied only once in mode
        if (ctrl_next[DMC_BIT])
          clk_ctrl_next.main_osc_en = 1'b0;
        else if (ctrl_next[HW_CTRL_MAIN_OSC_BIT] && link_sleep)
          clk_ctrl_next.main_osc_en = 1'b0;
        if (ctrl_next[DHC_BIT] || pll_power_down)
          clk_ctrl_next.pll_en = 1'b0;
        else if (ctrl_next[HW_CTRL_PLL_BIT] && link_sleep)
          clk_ctrl_next.pll_en = 1'b0;
      end
      ST_HALT_STOP:
        clk_ctrl_next.sys_clk_run = 1'b0;
      // halt: everything off whatever the disable bits hold
      ST_HALT:
      begin
        clk_ctrl_next.sys_clk_run = 1'b0;
        clk_ctrl_next.main_osc_en = 1'b0;
        clk_ctrl_next.pll_en = 1'b0;
      end
      ST_WAKE_MAIN:
      begin
        clk_ctrl_next.sys_clk_run = 1'b0;
        clk_ctrl_next.pll_en = 1'b0;
      end
      ST_WAKE_PLL:
        clk_ctrl_next.sys_clk_run = 1'b0;
      default:
        clk_ctrl_next.sys_clk_run = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clk_ctrl_reg <= CLK_CTRL_RESET;
    else
      clk_ctrl_reg <= clk_ctrl_next;
  end

  // ============================================================
  // apb slave, no wait states
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !rd_hit;
      // read data captured at setup, stands through the access cycle
      if (setup && !pwrite && paddr == CTRL_ADDR)
        prdata_reg <= {24'h00_0000, ctrl_reg};
      else if (setup && !pwrite && paddr == STAT_ADDR)
        prdata_reg <= status_word(clk_status);
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign clk_ctrl = clk_ctrl_reg;
  assign wake_pending = wake_reg;
  assign mode = mode_reg;

endmodule

// *** include/pmm_pkg.sv ***
package pmm_pkg;

  // ============================================================
  // register map (byte addresses, one word each)
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam int ADDR_W = 12;

  // ============================================================
  // control register fields
  localparam int PSM_BIT = 0;
  localparam int IDLE_BIT = 1;
  localparam int HALT_BIT = 2;
  localparam int WBE_BIT = 3;
  localparam int DMC_BIT = 4;
  localparam int DHC_BIT = 5;
  localparam int HW_CTRL_MAIN_OSC_BIT = 6;
  localparam int HW_CTRL_PLL_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ============================================================
  // status register fields
  localparam int LOW_STABLE_BIT = 0;
  localparam int MAIN_STABLE_BIT = 1;
  localparam int PLL_STABLE_BIT = 2;

  // ============================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int HALT_STOP_NS = 10;
  localparam int HALT_STOP_CYC =
    (HALT_STOP_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (HALT_STOP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SAVE,
    ST_IDLE,
    ST_HALT_STOP,
    ST_HALT,
    ST_WAKE_MAIN,
    ST_WAKE_PLL
  } pmode_e;

  // clock source status bundle
  typedef struct packed {
    logic pll_stable;
    logic main_osc_stable;
    logic low_osc_stable;
  } clk_status_s;

  // clock gating outputs
  typedef struct packed {
    logic sys_clk_run;
    logic sys_clk_slow;
    logic main_osc_en;
    logic pll_en;
  } clk_ctrl_s;

  localparam clk_ctrl_s CLK_CTRL_RESET = 4'hB;

endpackage

// *** verification/clock_source_model.sv ***
module clock_source_model
  import pmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic low_ok,
  input wire clk_ctrl_s ctrl,
  output clk_status_s st
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] main_cnt;
  logic [1:0] pll_cnt;
  // ==========
  // sources settle three cycles after enable
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      main_cnt <= 2'h0;
    else if (!ctrl.main_osc_en)
      main_cnt <= 2'h0;
    else if (main_cnt != 2'h3)
      main_cnt <= main_cnt + 2'h1;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      pll_cnt <= 2'h0;
    else if (!ctrl.pll_en || !ctrl.main_osc_en)
      pll_cnt <= 2'h0;
    else if (pll_cnt != 2'h3)
      pll_cnt <= pll_cnt + 2'h1;
  assign st.low_osc_stable = low_ok;
  assign st.main_osc_stable = main_cnt == 2'h3;
  assign st.pll_stable = !ctrl.pll_en || pll_cnt == 2'h3;
endmodule

// *** verification/pmm_monitor.sv ***
module pmm_monitor
  import pmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wake_event,
  input wire logic int_ack,
  input wire clk_status_s clk_status,
  input wire clk_ctrl_s clk_ctrl,
  input wire logic wake_pending,
  input wire pmode_e mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========
  // halt steps
  sequence s_stop;
    mode == ST_HALT_STOP && !clk_ctrl.sys_clk_run;
  endsequence
  sequence s_down;
    mode == ST_HALT && !clk_ctrl.main_osc_en && !clk_ctrl.pll_en;
  endsequence
  property p_halt_seq;
    $rose(mode == ST_HALT_STOP) |-> s_stop ##[1:8] s_down;
  endproperty
  a_halt_seq: assert property (p_halt_seq) else $error("halt order");
  property p_halt_off;
    mode == ST_HALT |-> s_down;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt clocks");
  property p_active_osc;
    mode == ST_ACTIVE |-> clk_ctrl.main_osc_en;
  endproperty
  a_active_osc: assert property (p_active_osc) else $error("osc off");
  property p_enter_active;
    mode == ST_ACTIVE && $past(mode) != ST_ACTIVE |->
      $past(clk_status.main_osc_stable) && $past(clk_status.pll_stable);
  endproperty
  a_enter_active: assert property (p_enter_active) else $error("unstable");
  property p_latch;
    wake_event |=> wake_pending;
  endproperty
  a_latch: assert property (p_latch) else $error("wake lost");
  property p_hold;
    wake_pending && !int_ack |=> wake_pending;
  endproperty
  a_hold: assert property (p_hold) else $error("wake dropped");
  property p_low;
    !clk_status.low_osc_stable && mode == ST_ACTIVE |=> mode == ST_ACTIVE;
  endproperty
  a_low: assert property (p_low) else $error("low mode entered");
  property p_wake;
    wake_event && mode == ST_HALT |-> ##[1:100] mode == ST_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule
bind power_mode_manager pmm_monitor u_mon (.mclk(mclk), .rst(rst), .wake_event(wake_event),
  .int_ack(int_ack), .clk_status(clk_status), .clk_ctrl(clk_ctrl),
  .wake_pending(wake_pending), .mode(mode));

// *** verification/power_mode_manager_tb_top.sv ***
module power_mode_manager_tb_top
  import pmm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic wait_exec = 1'h0, wake_event = 1'h0, int_ack = 1'h0, link_sleep = 1'h0;
  logic low_ok = 1'h1, pready, pslverr, err, wake_pending;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  clk_status_s clk_status;
  clk_ctrl_s clk_ctrl;
  pmode_e mode;
  int fails = 0, samples_checked = 0;
  // bit 31 of e stands for the error response
  row_s rows[5] = '{'{CTRL_ADDR, 32'hF8, 32'hF8}, '{CTRL_ADDR, 32'hFFFFFF08, 32'h8},
    '{STAT_ADDR, 32'hFF, 32'h7}, '{12'h8, 32'h1, 32'h80000000}, '{CTRL_ADDR, 32'h9, 32'h9}};
  power_mode_manager u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wait_exec(wait_exec), .wake_event(wake_event),
    .int_ack(int_ack), .link_sleep(link_sleep), .pll_power_down(1'h0),
    .clk_status(clk_status), .clk_ctrl(clk_ctrl), .wake_pending(wake_pending), .mode(mode));
  clock_source_model u_clk (.mclk(mclk), .rst(rst), .low_ok(low_ok), .ctrl(clk_ctrl),
    .st(clk_status));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk({err, rd[30:0]}, e);
  endtask
  task automatic wait_mode(input pmode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 60)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(mode), 32'(m));
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    wait_exec <= k == 0;
    wake_event <= k == 1;
    int_ack <= k == 2;
    @(posedge mclk);
    {wait_exec, wake_event, int_ack} <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // stimulus
  initial forever #2.5 mclk = ~mclk;
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      apb(1'h1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk(32'(mode), 32'(ST_ACTIVE));
    pulse(0);
    wait_mode(ST_SAVE);
    pulse(1);
    wait_mode(ST_ACTIVE);
    rchk(CTRL_ADDR, 32'h8);
    chk(32'(wake_pending), 32'h1);
    pulse(2);
    chk(32'(wake_pending), 32'h0);
    apb(1'h1, CTRL_ADDR, 32'h1);
    wait_mode(ST_SAVE);
    chk(32'(clk_ctrl[3:2]), 32'h3);
    rchk(CTRL_ADDR, 32'h1);
    apb(1'h1, CTRL_ADDR, 32'h0);
    wait_mode(ST_ACTIVE);
    apb(1'h1, CTRL_ADDR, 32'h3A);
    chk(32'(clk_ctrl[1:0]), 32'h3);
    pulse(0);
    wait_mode(ST_IDLE);
    repeat (2) @(posedge mclk);
    chk(32'(clk_ctrl[1:0]), 32'h0);
    pulse(1);
    wait_mode(ST_ACTIVE);
    rchk(CTRL_ADDR, 32'h8);
    pulse(2);
    apb(1'h1, CTRL_ADDR, 32'hC9);
    pulse(0);
    wait_mode(ST_SAVE);
    link_sleep <= 1'h1;
    repeat (2) @(posedge mclk);
    chk(32'(clk_ctrl[1:0]), 32'h0);
    link_sleep <= 1'h0;
    pulse(1);
    wait_mode(ST_ACTIVE);
    rchk(CTRL_ADDR, 32'h8);
    pulse(2);
    apb(1'h1, CTRL_ADDR, 32'hC);
    pulse(0);
    wait_mode(ST_HALT);
    pulse(1);
    wait_mode(ST_ACTIVE);
    rchk(CTRL_ADDR, 32'h8);
    pulse(2);
    low_ok <= 1'h0;
    rchk(STAT_ADDR, 32'h6);
    apb(1'h1, CTRL_ADDR, 32'h1);
    repeat (4) @(posedge mclk);
    chk(32'(mode), 32'(ST_ACTIVE));
    low_ok <= 1'h1;
    wait_mode(ST_SAVE);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    rchk(CTRL_ADDR, 32'h0);
    rchk(STAT_ADDR, 32'h7);
    low_ok <= 1'h0;
    apb(1'h1, CTRL_ADDR, 32'h9);
    pulse(0);
    rchk(CTRL_ADDR, 32'h9);
    chk(32'(mode), 32'(ST_ACTIVE));
    low_ok <= 1'h1;
    wait_mode(ST_SAVE);
    conclude();
  end
endmodule
